// ==== src/relay_port_pkg.sv ====
// Notes on behaviour
// - Eight byte registers at an eight-byte aligned base, low address bits select.
// - Any base address in the 16-bit I/O range is accepted.
// - Writes to +0 or +4 latch relay bytes; one energizes, zero releases.
// - D0..D7 drive relays 0-7 at +0 and relays 8-15 at +4.
// - Reads of +0 or +4 return the latched relay byte at any time.
// - Reset clears both relay latches, releasing every relay.
// - Reads of +1 and +5 return inputs 0-7 and 8-15, one energized.
// - Any read of +3 enables the 5 ms filter on all inputs.
// - Any write to +3 disables the filter; data is ignored.
// - Read of +7 returns ff with filter on, 00 with it off.
// - Any read of +2 enables the input change interrupt.
// - Any write to +2 disables the input change interrupt.
// - Any write to +1 clears the pending request and releases the line, unless an enabled change raises it in the same cycle.
// - Read of +6: bits 0,1 interrupt enabled, bit 2 raised, rest zero.
// - When enabled, any filtered input change in either direction raises a request.
// - Interrupt enable is off after reset.
// - Filter enable is off after reset.
// - The request drives the first shared bus interrupt line.
package relay_port_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int CHANNELS = 16;
    localparam logic [2:0] OFF_RELAY_LO = 3'h0;
    localparam logic [2:0] OFF_INPUT_LO = 3'h1;
    localparam logic [2:0] OFF_IRQ_CTL = 3'h2;
    localparam logic [2:0] OFF_FILT_CTL = 3'h3;
    localparam logic [2:0] OFF_RELAY_HI = 3'h4;
    localparam logic [2:0] OFF_INPUT_HI = 3'h5;
    localparam logic [2:0] OFF_IRQ_STAT = 3'h6;
    localparam logic [2:0] OFF_FILT_STAT = 3'h7;
    localparam int STAT_EN0_BIT = 0;
    localparam int STAT_EN1_BIT = 1;
    localparam int STAT_RAISED_BIT = 2;
    localparam logic [7:0] FILT_ON_BYTE = 8'hff;
    localparam logic [7:0] FILT_OFF_BYTE = 8'h00;
    localparam logic [15:0] RELAY_RESET = 16'h0000;
    localparam int CLOCK_MHZ = 100;
    localparam int FILTER_TIME_US = 5000;
    localparam int FILTER_CYCLES = FILTER_TIME_US * CLOCK_MHZ;
    localparam int FILT_CNT_W = $clog2(FILTER_CYCLES + 1);

    // One host I/O access
    typedef struct packed {
        logic rd;
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } io_req_t;
endpackage

// ==== src/isolated_input_relay_port.sv ====
module isolated_input_relay_port #(
    parameter int unsigned FILTER_CYCLES = relay_port_pkg::FILTER_CYCLES
) (
    input wire logic clock, // 100 MHz bus clock
    input wire logic reset, // Synchronous, active high
    input wire logic clock_enable, // Low freezes all state
    input wire logic [15:3] base_addr, // Assigned I/O base
    input wire relay_port_pkg::io_req_t io_req, // Read or write strobe, address, data
    input wire logic [15:0] isolated_input, // Field inputs, asynchronous
    output logic [7:0] io_rdata, // Read data, one cycle after request
    output logic io_rvalid, // Read data valid pulse
    output logic [15:0] relay_output, // Relay drivers, one energizes
    output logic int_out, // Interrupt pin level, always low
    output logic int_oe // Interrupt pin driven while high
);
    localparam int CW = relay_port_pkg::FILT_CNT_W;

    // Input path: synchroniser pair, filtered level and its last value
    logic [15:0] sync_a;
    logic [15:0] sync_b;
    logic [15:0] filt;
    logic [15:0] prev_filt;
    logic [15:0] next_prev_filt;
    // Control state, set and cleared as side effects of bus accesses; the request flag is also set by input changes
    logic filter_en;
    logic next_filter_en;
    logic irq_en;
    logic next_irq_en;
    logic irq_flag;
    logic next_irq_flag;
    logic [15:0] next_relay;
    logic [7:0] next_rdata;
    logic next_rvalid;
    logic next_int_oe;
    // Decode of the request that stands in this cycle
    logic hit;
    logic rd_take;
    logic wr_take;
    logic [2:0] off;
    logic change;

    // Field inputs cross two flops before anything looks at them
    always_ff @(posedge clock) begin
        if (reset) begin
            sync_a <= '0;
            sync_b <= '0;
        end else if (clock_enable) begin
            sync_a <= isolated_input;
            sync_b <= sync_a;
        end
    end

    // Per input filter: the output follows only after a steady run
    genvar gi;
    generate
        for (gi = 0; gi < relay_port_pkg::CHANNELS; gi++) begin : g_filter
            logic [CW-1:0] cnt;
            logic [CW-1:0] next_cnt;
            logic next_filt;

            // Filter off passes the synced level straight through
            always_comb begin
                next_cnt = '0;
                next_filt = sync_b[gi];
                if (filter_en) begin
                    next_filt = filt[gi];
                    if (sync_b[gi] != filt[gi]) begin
                        if (cnt >= CW'(FILTER_CYCLES - 1)) begin
                            next_filt = sync_b[gi];
                        end else begin
                            next_cnt = cnt + CW'(1);
                        end
                    end
                end
            end

            always_ff @(posedge clock) begin
                if (reset) begin
                    cnt <= '0;
                    filt[gi] <= 1'b0;
                end else if (clock_enable) begin
                    cnt <= next_cnt;
                    filt[gi] <= next_filt;
                end
            end
        end
    endgenerate

    // Decode against the full 16-bit base; offsets are the low three bits
    assign off = io_req.addr[2:0];
    assign hit = io_req.addr[15:3] == base_addr;
    assign rd_take = io_req.rd && hit;
    assign wr_take = io_req.wr && hit && !io_req.rd;
    assign change = |(filt ^ prev_filt);

    // Register file, access side effects and interrupt request
    always_comb begin
        next_relay = relay_output;
        next_filter_en = filter_en;
        next_irq_en = irq_en;
        next_irq_flag = irq_flag;
        next_rdata = io_rdata;
        next_rvalid = rd_take;
        next_prev_filt = filt;
        if (wr_take) begin
            case (off)
                relay_port_pkg::OFF_RELAY_LO: next_relay[7:0] = io_req.wdata;
                relay_port_pkg::OFF_RELAY_HI: next_relay[15:8] = io_req.wdata;
                relay_port_pkg::OFF_INPUT_LO: next_irq_flag = 1'b0;
                relay_port_pkg::OFF_IRQ_CTL: next_irq_en = 1'b0;
                relay_port_pkg::OFF_FILT_CTL: next_filter_en = 1'b0;
                default: next_relay = relay_output;
            endcase
        end
        if (rd_take) begin
            case (off)
                relay_port_pkg::OFF_RELAY_LO: next_rdata = relay_output[7:0];
                relay_port_pkg::OFF_RELAY_HI: next_rdata = relay_output[15:8];
                relay_port_pkg::OFF_INPUT_LO: next_rdata = filt[7:0];
                relay_port_pkg::OFF_INPUT_HI: next_rdata = filt[15:8];
                relay_port_pkg::OFF_IRQ_CTL: begin
                    next_irq_en = 1'b1;
                    next_rdata = 8'h00;
                end
                relay_port_pkg::OFF_FILT_CTL: begin
                    next_filter_en = 1'b1;
                    next_rdata = 8'h00;
                end
                relay_port_pkg::OFF_IRQ_STAT: begin
                    next_rdata = 8'h00;
                    next_rdata[relay_port_pkg::STAT_EN0_BIT] = irq_en;
                    next_rdata[relay_port_pkg::STAT_EN1_BIT] = irq_en;
                    next_rdata[relay_port_pkg::STAT_RAISED_BIT] = irq_flag;
                end
                relay_port_pkg::OFF_FILT_STAT: begin
                    next_rdata = filter_en ? relay_port_pkg::FILT_ON_BYTE
                                           : relay_port_pkg::FILT_OFF_BYTE;
                end
                default: next_rdata = 8'h00;
            endcase
        end
        // A change in the clear cycle still raises: set beats clear
        if (irq_en && change) begin
            next_irq_flag = 1'b1;
        end
        next_int_oe = next_irq_flag && next_irq_en;
    end

    // Reset leaves relays released, filter and interrupt off
    always_ff @(posedge clock) begin
        if (reset) begin
            relay_output <= relay_port_pkg::RELAY_RESET;
            filter_en <= 1'b0;
            irq_en <= 1'b0;
            irq_flag <= 1'b0;
            prev_filt <= '0;
            io_rdata <= 8'h00;
            io_rvalid <= 1'b0;
            int_oe <= 1'b0;
            int_out <= 1'b0;
        end else if (clock_enable) begin
            relay_output <= next_relay;
            filter_en <= next_filter_en;
            irq_en <= next_irq_en;
            irq_flag <= next_irq_flag;
            prev_filt <= next_prev_filt;
            io_rdata <= next_rdata;
            io_rvalid <= next_rvalid;
            int_oe <= next_int_oe;
            int_out <= 1'b0;
        end
    end

    // Checks on the bus side of the block
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    sequence rd_at(logic [2:0] o);
        clock_enable && rd_take && off == o;
    endsequence

    sequence wr_at(logic [2:0] o);
        clock_enable && wr_take && off == o;
    endsequence

    // A read of either control strobe address
    sequence ctl_rd;
        rd_at(relay_port_pkg::OFF_IRQ_CTL) or rd_at(relay_port_pkg::OFF_FILT_CTL);
    endsequence

    // Bus answers and decode
    read_valid_a: assert property (clock_enable && rd_take |=> io_rvalid)
        else $error("read not answered");
    rvalid_drop_a: assert property (clock_enable && !rd_take |=> !io_rvalid)
        else $error("read strobe without a read");
    miss_quiet_a: assert property (clock_enable && !hit
        |=> !io_rvalid && $stable(relay_output))
        else $error("access outside base took effect");
    miss_ctl_a: assert property (clock_enable && !hit
        |=> $stable(filter_en) && $stable(irq_en))
        else $error("access outside base moved a control bit");
    rd_wins_a: assert property (clock_enable && io_req.rd && io_req.wr && hit
        |=> io_rvalid && $stable(relay_output))
        else $error("read and write together not taken as read");

    // Relay latches move only on reset or on a write that hits their own offset
    relay_lo_a: assert property (wr_at(relay_port_pkg::OFF_RELAY_LO)
        |=> relay_output[7:0] == $past(io_req.wdata))
        else $error("low relay byte not latched");
    relay_hi_a: assert property (wr_at(relay_port_pkg::OFF_RELAY_HI)
        |=> relay_output[15:8] == $past(io_req.wdata) && $stable(relay_output[7:0]))
        else $error("high relay byte not latched");
    relay_keep_a: assert property (clock_enable && !(wr_take
        && (off == relay_port_pkg::OFF_RELAY_LO || off == relay_port_pkg::OFF_RELAY_HI))
        |=> $stable(relay_output))
        else $error("relay latch moved without a write");
    relay_back_a: assert property (rd_at(relay_port_pkg::OFF_RELAY_HI)
        |=> io_rdata == relay_output[15:8])
        else $error("relay readback wrong");
    relay_lo_back_a: assert property (rd_at(relay_port_pkg::OFF_RELAY_LO)
        |=> io_rdata == relay_output[7:0])
        else $error("low relay readback wrong");
    rdata_hold_a: assert property (clock_enable && !rd_take |=> $stable(io_rdata))
        else $error("read data moved without a read");
    reset_state_a: assert property (disable iff (1'b0) reset
        |=> relay_output == relay_port_pkg::RELAY_RESET && !filter_en && !irq_en && !int_oe)
        else $error("reset state wrong");

    // Input path and filter
    sync_step_a: assert property (clock_enable |=> sync_b == $past(sync_a))
        else $error("synchroniser skipped a stage");
    input_read_a: assert property (rd_at(relay_port_pkg::OFF_INPUT_LO)
        |=> io_rdata == $past(filt[7:0]))
        else $error("input byte wrong");
    input_hi_a: assert property (rd_at(relay_port_pkg::OFF_INPUT_HI)
        |=> io_rdata == $past(filt[15:8]))
        else $error("high input byte wrong");
    filter_on_a: assert property (rd_at(relay_port_pkg::OFF_FILT_CTL)
        |=> filter_en ##1 (filter_en || $past(wr_take) || !$past(clock_enable)))
        else $error("filter not enabled");
    filter_keep_a: assert property (clock_enable && filter_en && filt == sync_b
        |=> filt == $past(filt))
        else $error("filtered level moved on a steady input");
    filter_off_a: assert property (wr_at(relay_port_pkg::OFF_FILT_CTL) |=> !filter_en)
        else $error("filter not disabled");
    filter_pass_a: assert property (clock_enable && !filter_en
        |=> filt == $past(sync_b))
        else $error("unfiltered level does not follow input");
    filter_stat_a: assert property (rd_at(relay_port_pkg::OFF_FILT_STAT)
        |=> io_rdata == (filter_en ? 8'hff : 8'h00))
        else $error("filter status wrong");
    strobe_zero_a: assert property (ctl_rd |=> io_rdata == 8'h00)
        else $error("control strobe read not zero");

    // Interrupt enable, request flag and line
    irq_on_a: assert property (rd_at(relay_port_pkg::OFF_IRQ_CTL) |=> irq_en)
        else $error("interrupt not enabled");
    irq_off_a: assert property (wr_at(relay_port_pkg::OFF_IRQ_CTL) |=> !irq_en && !int_oe)
        else $error("interrupt not disabled");
    irq_clear_a: assert property (wr_at(relay_port_pkg::OFF_INPUT_LO)
        && !(irq_en && change) |=> !irq_flag && !int_oe)
        else $error("request not cleared");
    irq_stat_a: assert property (rd_at(relay_port_pkg::OFF_IRQ_STAT)
        |=> io_rdata[7:3] == 5'h00 && io_rdata[1:0] == {2{irq_en}}
        && io_rdata[2] == $past(irq_flag))
        else $error("interrupt status wrong");
    change_raise_a: assert property (clock_enable && irq_en && change |=> irq_flag)
        else $error("change did not raise request");
    no_raise_off_a: assert property (clock_enable && !irq_en && !irq_flag
        |=> !irq_flag && !int_oe)
        else $error("request raised while disabled");
    flag_hold_a: assert property (clock_enable && irq_flag
        && !(wr_take && off == relay_port_pkg::OFF_INPUT_LO) |=> irq_flag)
        else $error("request dropped without a clear");
    unused_wr_a: assert property (wr_at(relay_port_pkg::OFF_FILT_STAT) && !change
        |=> $stable(relay_output) && $stable(filter_en) && $stable(irq_en)
        && $stable(irq_flag))
        else $error("unused write changed state");
    line_gate_a: assert property (int_oe == (irq_flag && irq_en) && !int_out)
        else $error("interrupt line not gated");

    // A low clock enable must hold every register, outputs included
    freeze_a: assert property (!clock_enable
        |=> $stable(relay_output) && $stable(io_rdata) && $stable(io_rvalid)
        && $stable(int_oe) && $stable(filter_en) && $stable(irq_en) && $stable(irq_flag))
        else $error("state moved while frozen");
endmodule

// ==== tb/host_model.sv ====
module host_model (
    input wire logic clock, // Bus clock
    input wire logic [7:0] io_rdata, // Read data from the card
    input wire logic io_rvalid, // Read data strobe
    input wire logic int_oe, // Card pulls the interrupt line
    output relay_port_pkg::io_req_t io_req // Host I/O access
);
    timeunit 1ns;
    timeprecision 1ps;

    initial io_req = '0;

    // One I/O cycle, launched and released on falling edges
    task automatic access(input logic wr, input logic [15:0] addr, input logic [7:0] data,
                          output logic [7:0] rd_data);
        rd_data = 8'hxx;
        @(negedge clock);
        io_req.rd = !wr;
        io_req.wr = wr;
        io_req.addr = addr;
        io_req.wdata = data;
        @(negedge clock);
        io_req.rd = 1'b0;
        io_req.wr = 1'b0;
        // Released lines toggle so a stale address never looks like a live one
        io_req.addr = ~io_req.addr;
        io_req.wdata = ~io_req.wdata;
        for (int i = 0; i < 4 && !wr; i++) begin
            if (io_rvalid === 1'b1) begin
                rd_data = io_rdata;
                break;
            end
            @(negedge clock);
        end
    endtask

    // Interrupt service: waits a bounded time, then clears only if the line was seen
    task automatic service(input logic [15:0] clr_addr, output logic seen);
        logic [7:0] r;
        seen = 1'b0;
        for (int i = 0; i < 12 && !seen; i++) begin
            @(negedge clock);
            seen = (int_oe === 1'b1);
        end
        if (seen) access(1'b1, clr_addr, 8'h00, r);
    endtask
endmodule

// ==== tb/isolated_input_relay_port_test.sv ====
`define chk(what, exp, got) begin checks++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected %s: expected %h, seen %h", what, exp, got); end end

module isolated_input_relay_port_test;
    timeunit 1ns;
    timeprecision 1ps;

    // Short debounce keeps the run brief
    localparam int FILT = 8;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic clock_enable = 1'b1;
    logic [15:3] base_addr = 13'h1e60;
    logic [15:0] isolated_input = 16'h0000;
    relay_port_pkg::io_req_t io_req;
    logic [7:0] io_rdata;
    logic io_rvalid;
    logic [15:0] relay_output;
    logic int_out;
    logic int_oe;
    logic seen;
    logic [7:0] r;
    int n_errors = 0;
    int checks = 0;

    always #5 clock = ~clock;

    isolated_input_relay_port #(.FILTER_CYCLES(FILT)) dut (.clock(clock), .reset(reset),
        .clock_enable(clock_enable), .base_addr(base_addr), .io_req(io_req),
        .isolated_input(isolated_input), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .relay_output(relay_output), .int_out(int_out), .int_oe(int_oe));

    host_model host (.clock(clock), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .int_oe(int_oe), .io_req(io_req));

    task automatic wr(input logic [2:0] off, input logic [7:0] d);
        host.access(1'b1, {base_addr, off}, d, r);
    endtask

    task automatic rd_chk(input logic [2:0] off, input logic [7:0] exp);
        host.access(1'b0, {base_addr, off}, 8'h00, r);
        `chk("io_rdata", exp, r)
    endtask

    task automatic t_reset;
        `chk("relay_output", 16'h0000, relay_output)
        rd_chk(3'h0, 8'h00);
        rd_chk(3'h4, 8'h00);
        rd_chk(3'h6, 8'h00);
        rd_chk(3'h7, 8'h00);
        `chk("int_oe", 1'b0, int_oe)
    endtask

    task automatic t_relays;
        wr(3'h0, 8'h81);
        wr(3'h4, 8'ha5);
        `chk("relay_output", 16'ha581, relay_output)
        rd_chk(3'h0, 8'h81);
        rd_chk(3'h4, 8'ha5);
        wr(3'h5, 8'hff);
        wr(3'h6, 8'hff);
        wr(3'h7, 8'hff);
        `chk("relay_output", 16'ha581, relay_output)
        rd_chk(3'h7, 8'h00);
        // Next block up must not hit
        host.access(1'b1, {base_addr + 13'h0001, 3'h0}, 8'h00, r);
        `chk("relay_output", 16'ha581, relay_output)
        base_addr = 13'h1fff;
        wr(3'h4, 8'h3c);
        `chk("relay_output", 16'h3c81, relay_output)
        rd_chk(3'h0, 8'h81);
    endtask

    task automatic t_inputs;
        isolated_input = 16'h3c96;
        repeat (5) @(negedge clock);
        rd_chk(3'h1, 8'h96);
        rd_chk(3'h5, 8'h3c);
    endtask

    task automatic t_filter;
        rd_chk(3'h3, 8'h00);
        rd_chk(3'h7, 8'hff);
        isolated_input = 16'h3c69;
        repeat (4) @(negedge clock);
        rd_chk(3'h1, 8'h96);
        repeat (FILT + 4) @(negedge clock);
        rd_chk(3'h1, 8'h69);
        wr(3'h3, 8'h5a);
        rd_chk(3'h7, 8'h00);
        isolated_input = 16'h3c96;
        repeat (4) @(negedge clock);
        rd_chk(3'h1, 8'h96);
    endtask

    task automatic t_irq;
        rd_chk(3'h2, 8'h00);
        rd_chk(3'h6, 8'h03);
        `chk("int_oe", 1'b0, int_oe)
        isolated_input = isolated_input ^ 16'h8000;
        for (int i = 0; i < 12 && int_oe !== 1'b1; i++) @(negedge clock);
        `chk("int_oe", 1'b1, int_oe)
        `chk("int_out", 1'b0, int_out)
        rd_chk(3'h6, 8'h07);
        repeat (6) @(negedge clock);
        `chk("int_oe", 1'b1, int_oe)
        host.service({base_addr, 3'h1}, seen);
        `chk("int_oe", 1'b0, int_oe)
        rd_chk(3'h6, 8'h03);
        // Opposite direction must signal too
        isolated_input = isolated_input ^ 16'h8000;
        host.service({base_addr, 3'h1}, seen);
        `chk("seen", 1'b1, seen)
        wr(3'h2, 8'h77);
        rd_chk(3'h6, 8'h00);
        isolated_input = isolated_input ^ 16'h0001;
        repeat (8) @(negedge clock);
        `chk("int_oe", 1'b0, int_oe)
    endtask

    // Mid-run reset must drop relays, filter and interrupt enable again
    task automatic t_restart;
        wr(3'h0, 8'hff);
        rd_chk(3'h2, 8'h00);
        rd_chk(3'h3, 8'h00);
        reset = 1'b1;
        repeat (2) @(negedge clock);
        reset = 1'b0;
        t_reset();
    endtask

    // A low clock enable freezes the latches; the same write lands once it is high
    task automatic t_cken;
        clock_enable = 1'b0;
        wr(3'h0, 8'h5a);
        `chk("relay_output", 16'h0000, relay_output)
        clock_enable = 1'b1;
        wr(3'h0, 8'h5a);
        `chk("relay_output", 16'h005a, relay_output)
    endtask

    task automatic wrap_up;
        $display("checks %0d, n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // Whole run needs well under a thousand cycles
    initial begin
        #20000;
        n_errors++;
        wrap_up();
    end

    initial begin
        repeat (16) @(negedge clock);
        reset = 1'b0;
        t_reset();
        t_relays();
        t_inputs();
        t_filter();
        t_irq();
        t_restart();
        t_cken();
        wrap_up();
    end
endmodule
